// File: rtl/bts_pkg.sv
// Constants and types for the burst trigger sequencer
// What this block does
// - Enabling burst forces sweep and modulation off; never both active.
// - Burst enable resets off; reads back 0 off, 1 on.
// - Phase entered in degrees or radians; display shows degrees.
// - Triggered burst emits configured cycles per trigger, then halts.
// - Trigger source: internal repeat, external edge, bus; default internal.
// - Internal source restarts bursts every programmed repeat interval.
// - External source starts one burst per edge of selected polarity.
// - External edges during a burst are ignored.
// - Bus source starts burst per bus command; indicator lit while waiting.
// - External or bus source ignores repeat interval, keeps count, phase.
// - Combined setup command forces source to internal repeat.
// - Burst completion sets event bit 0 or answers 1 if pending.
// - External edge selector rising or falling; default rising.
// - Gate polarity active high or low; default active high.
// - Trigger-out, default off, gives selected edge at burst start.
// - Internal source trigger-out is 50% square at repeat interval in triggered burst; held constant in sweep.
// - External source or gated operation suppresses trigger-out.
// - Bus source trigger-out is one pulse over 1 us per burst.
// - Generic trigger command starts a burst under any source.
// - Dedicated bus trigger starts burst only with bus source selected.
// - Host waits between triggers; device finishes pending work first.
// - Gated output runs while gate true, finishes cycle, holds phase.
// - Cycles per burst 1 to 50000 or infinite; default one.
package bts_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_NCYC = 8'h04;
    localparam logic [7:0] ADDR_PER = 8'h08;
    localparam logic [7:0] ADDR_PHASE = 8'h0c;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [7:0] ADDR_PHDEG = 8'h18;
    // ****************************************
    // Control field positions
    // ****************************************
    localparam int CB_BURST = 0;
    localparam int CB_UNIT = 1;
    localparam int CB_SRC = 2;
    localparam int CB_MODE = 4;
    localparam int CB_EDGE = 5;
    localparam int CB_GPOL = 6;
    localparam int CB_TOEN = 7;
    localparam int CB_TOEDGE = 8;
    localparam int CB_SWEEP = 9;
    localparam int CB_MOD = 10;
    localparam int CMD_TRIG = 0;
    localparam int CMD_TRG = 1;
    localparam int CMD_COMBINED_SETUP_COMMAND = 2;
    localparam int CMD_OPC = 3;
    localparam int CMD_OPCQ = 4;
    localparam int CMD_CLRESR = 5;
    // ****************************************
    // Values and timing
    // ****************************************
    localparam logic [15:0] NCYC_MIN = 16'h0001;
    localparam logic [15:0] NCYC_MAX = 16'hc350;
    localparam logic [15:0] NCYC_INF = 16'h0000;
    localparam logic [31:0] PER_RESET = 32'h000f4240;
    localparam logic [31:0] PER_MIN = 32'h00000064;
    localparam int CLK_MHZ = 100;
    localparam int OUT_PULSE_NS = 1000;
    localparam int OUT_PULSE_CYC = OUT_PULSE_NS * CLK_MHZ / 1000 + 1;
    // Radian fixed point: phase in 1/1024 rad, degrees in 1/16 deg
    localparam logic [31:0] RAD2DEG = 32'h00000395;
    localparam int RAD2DEG_SHIFT = 10;
    typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_BUS} bts_src_t;
    typedef struct packed {
        logic modulation;
        logic sweep;
        logic trig_out_edge;
        logic trig_out_en;
        logic gate_pol;
        logic trig_edge;
        logic gated;
        bts_src_t src;
        logic phase_unit;
        logic burst_en;
    } bts_ctrl_t;
    localparam bts_ctrl_t CTRL_RESET = '0;
endpackage

// File: rtl/bts_sync.sv
// Two-stage synchroniser with edge and level detection
`timescale 1ns/1ns
module bts_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic d,
    input wire logic edge_falling,
    output logic level,
    output logic edge_seen
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    // ****************************************
    // Synchroniser and detector
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else if (ce)
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign level = s2_q;
    assign edge_seen = ce & (edge_falling ? (s3_q & ~s2_q)
                                          : (~s3_q & s2_q));
endmodule

// File: rtl/bts_top.sv
// Burst trigger sequencer with APB registers
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module bts_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trig_in,
    input wire logic cycle_end,
    output logic trig_out,
    output logic trig_out_oe,
    output logic wave_run,
    output logic wave_restart,
    output logic manual_lamp,
    output logic sweep_active,
    output logic modulation_active
);
    // ****************************************
    // State and registers
    // ****************************************
    typedef enum logic [1:0] {ST_IDLE, ST_BURST, ST_GATE} bts_state_t;
    bts_state_t state_q;
    bts_state_t state_d;
    bts_pkg::bts_ctrl_t ctrl_q;
    bts_pkg::bts_ctrl_t ctrl_d;
    logic [15:0] ncyc_q;
    logic [31:0] per_q;
    logic [31:0] phase_q;
    logic [31:0] phdeg_q;
    logic [15:0] cyc_cnt_q;
    logic [31:0] per_cnt_q;
    logic [7:0] pulse_cnt_q;
    logic opc_pend_q;
    logic esr_opc_q;
    logic opcq_pend_q;
    logic opcq_ans_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic trig_out_q;
    logic wave_run_q;
    logic restart_q;
    logic lamp_q;
    logic oe_q;
    // ****************************************
    // Decoding
    // ****************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction
    wire setup = psel & ~penable;
    wire acc = psel & penable & clk_en;
    wire wr = acc & pwrite;
    wire rd_setup = setup & ~pwrite;
    wire wr_ctrl = wr & hit(paddr, bts_pkg::ADDR_CTRL);
    wire wr_ncyc = wr & hit(paddr, bts_pkg::ADDR_NCYC);
    wire wr_per = wr & hit(paddr, bts_pkg::ADDR_PER);
    wire wr_phase = wr & hit(paddr, bts_pkg::ADDR_PHASE);
    wire wr_cmd = wr & hit(paddr, bts_pkg::ADDR_CMD);
    wire mapped = hit(paddr, bts_pkg::ADDR_CTRL)
                | hit(paddr, bts_pkg::ADDR_NCYC)
                | hit(paddr, bts_pkg::ADDR_PER)
                | hit(paddr, bts_pkg::ADDR_PHASE)
                | hit(paddr, bts_pkg::ADDR_CMD)
                | hit(paddr, bts_pkg::ADDR_STAT)
                | hit(paddr, bts_pkg::ADDR_PHDEG);
    wire cmd_trig = wr_cmd & pwdata[bts_pkg::CMD_TRIG];
    wire cmd_trg = wr_cmd & pwdata[bts_pkg::CMD_TRG];
    wire cmd_combined_setup_command = wr_cmd & pwdata[bts_pkg::CMD_COMBINED_SETUP_COMMAND];
    wire cmd_opc = wr_cmd & pwdata[bts_pkg::CMD_OPC];
    wire cmd_opcq = wr_cmd & pwdata[bts_pkg::CMD_OPCQ];
    wire cmd_clr = wr_cmd & pwdata[bts_pkg::CMD_CLRESR];
    // ****************************************
    // Trigger input
    // ****************************************
    logic gate_lvl;
    logic ext_edge;
    bts_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(clk_en),
        .d(trig_in),
        .edge_falling(ctrl_q.trig_edge),
        .level(gate_lvl),
        .edge_seen(ext_edge)
    );
    wire gate_true = gate_lvl ^ ctrl_q.gate_pol;
    // ****************************************
    // Trigger selection
    // ****************************************
    wire per_done = (per_cnt_q == 32'h0) | (per_cnt_q == 32'h1);
    wire src_int = ctrl_q.src == bts_pkg::SRC_INT;
    wire src_ext = ctrl_q.src == bts_pkg::SRC_EXT;
    wire src_bus = ctrl_q.src == bts_pkg::SRC_BUS;
    wire triggered = ctrl_q.burst_en & ~ctrl_q.gated;
    wire int_fire = triggered & src_int & per_done;
    wire ext_fire = triggered & src_ext & ext_edge
                  & (state_q == ST_IDLE);
    wire bus_fire = triggered & src_bus & cmd_trg;
    wire gen_fire = triggered & cmd_trig;
    wire start = (state_q == ST_IDLE)
               & (int_fire | ext_fire | bus_fire | gen_fire);
    wire last_cyc = cycle_end & (ncyc_q != bts_pkg::NCYC_INF)
                  & (cyc_cnt_q == ncyc_q - bts_pkg::NCYC_MIN);
    wire burst_done = (state_q == ST_BURST) & clk_en & last_cyc;
    wire [31:0] half_per = {1'b0, per_q[31:1]};
    wire to_allowed = ctrl_q.trig_out_en & ~src_ext & ~ctrl_q.gated
                    & (ctrl_q.burst_en | ctrl_q.sweep);
    // ****************************************
    // Phase in degrees
    // ****************************************
    wire [63:0] ph_prod = $signed(phase_q) * $signed(bts_pkg::RAD2DEG);
    wire [31:0] ph_deg = ctrl_q.phase_unit
                       ? 32'(ph_prod >>> bts_pkg::RAD2DEG_SHIFT)
                       : phase_q;
    // ****************************************
    // Control next value
    // ****************************************
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ctrl)
        begin
            ctrl_d = bts_pkg::bts_ctrl_t'(pwdata[10:0]);
            if (pwdata[bts_pkg::CB_BURST])
            begin
                ctrl_d.sweep = 1'b0;
                ctrl_d.modulation = 1'b0;
            end
            else if (ctrl_q.burst_en & pwdata[bts_pkg::CB_SWEEP])
                ctrl_d.burst_en = 1'b0;
            else if (ctrl_q.burst_en & pwdata[bts_pkg::CB_MOD])
                ctrl_d.burst_en = 1'b0;
            if (pwdata[bts_pkg::CB_SRC +: 2] == 2'h3)
                ctrl_d.src = ctrl_q.src;
        end
        if (cmd_combined_setup_command)
            ctrl_d.src = bts_pkg::SRC_INT;
    end
    // ****************************************
    // Sequencer
    // ****************************************
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
                if (ctrl_q.burst_en & ctrl_q.gated & gate_true)
                    state_d = ST_GATE;
                else if (start)
                    state_d = ST_BURST;
            ST_BURST:
                if (!ctrl_q.burst_en | last_cyc)
                    state_d = ST_IDLE;
            ST_GATE:
                if (!ctrl_q.burst_en | (!gate_true & cycle_end))
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end
    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= bts_pkg::CTRL_RESET;
            ncyc_q <= bts_pkg::NCYC_MIN;
            per_q <= bts_pkg::PER_RESET;
            phase_q <= 32'h0;
            phdeg_q <= 32'h0;
        end
        else if (clk_en)
        begin
            ctrl_q <= ctrl_d;
            phdeg_q <= ph_deg;
            if (wr_ncyc && pwdata[15:0] <= bts_pkg::NCYC_MAX)
                ncyc_q <= pwdata[15:0];
            if (wr_per && pwdata >= bts_pkg::PER_MIN)
                per_q <= pwdata;
            if (wr_phase)
                phase_q <= pwdata;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
            cyc_cnt_q <= 16'h0;
            per_cnt_q <= 32'h0;
            restart_q <= 1'b0;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            restart_q <= start;
            if (start)
                cyc_cnt_q <= 16'h0;
            else if (state_q == ST_BURST && cycle_end)
                cyc_cnt_q <= cyc_cnt_q + 16'h1;
            if (!triggered || !src_int || per_done)
                per_cnt_q <= per_q;
            else
                per_cnt_q <= per_cnt_q - 32'h1;
        end
    end
    // ****************************************
    // Operation complete
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opc_pend_q <= 1'b0;
            esr_opc_q <= 1'b0;
            opcq_pend_q <= 1'b0;
            opcq_ans_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (burst_done & opc_pend_q)
                esr_opc_q <= 1'b1;
            else if (cmd_clr)
                esr_opc_q <= 1'b0;
            if (burst_done & opcq_pend_q)
                opcq_ans_q <= 1'b1;
            else if (cmd_clr)
                opcq_ans_q <= 1'b0;
            if (burst_done)
                opc_pend_q <= 1'b0;
            else if (cmd_opc)
                opc_pend_q <= 1'b1;
            if (burst_done)
                opcq_pend_q <= 1'b0;
            else if (cmd_opcq)
                opcq_pend_q <= 1'b1;
        end
    end
    // ****************************************
    // Trigger out and outputs
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trig_out_q <= 1'b0;
            pulse_cnt_q <= 8'h0;
            wave_run_q <= 1'b0;
            lamp_q <= 1'b0;
        end
        else if (clk_en)
        begin
            wave_run_q <= (state_d != ST_IDLE);
            lamp_q <= triggered & src_bus & (state_d == ST_IDLE);
            if (start)
                pulse_cnt_q <= 8'(bts_pkg::OUT_PULSE_CYC);
            else if (pulse_cnt_q != 8'h0)
                pulse_cnt_q <= pulse_cnt_q - 8'h1;
            if (!to_allowed)
                trig_out_q <= ctrl_q.trig_out_edge;
            else if (src_int)
                trig_out_q <= ctrl_q.trig_out_edge
                            ^ (per_cnt_q > half_per);
            else
                trig_out_q <= ctrl_q.trig_out_edge
                            ^ (start | (pulse_cnt_q > 8'h1));
        end
    end
    // ****************************************
    // APB slave
    // ****************************************
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0;
        if (hit(paddr, bts_pkg::ADDR_CTRL))
            rd_mux = {21'h0, ctrl_q};
        else if (hit(paddr, bts_pkg::ADDR_NCYC))
            rd_mux = {16'h0, ncyc_q};
        else if (hit(paddr, bts_pkg::ADDR_PER))
            rd_mux = per_q;
        else if (hit(paddr, bts_pkg::ADDR_PHASE))
            rd_mux = phase_q;
        else if (hit(paddr, bts_pkg::ADDR_STAT))
            rd_mux = {26'h0, opcq_ans_q, esr_opc_q, lamp_q,
                      wave_run_q, state_q};
        else if (hit(paddr, bts_pkg::ADDR_PHDEG))
            rd_mux = phdeg_q;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else if (clk_en)
        begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            if (rd_setup)
                prdata_q <= rd_mux;
        end
        else
            pready_q <= 1'b0;
    end
    // ****************************************
    // Pin drive enable
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            oe_q <= 1'b0;
        else if (clk_en)
            oe_q <= (ctrl_d.src != bts_pkg::SRC_EXT) & ~ctrl_d.gated;
    end
    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign trig_out = trig_out_q;
    assign trig_out_oe = oe_q;
    assign wave_run = wave_run_q;
    assign wave_restart = restart_q;
    assign manual_lamp = lamp_q;
    assign sweep_active = ctrl_q.sweep;
    assign modulation_active = ctrl_q.modulation;
endmodule

// File: testbench/bts_chk.sv
// Port checker for the burst trigger sequencer
`timescale 1ns/1ns
module bts_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic trig_in,
    input wire logic cycle_end,
    input wire logic trig_out,
    input wire logic trig_out_oe,
    input wire logic wave_run,
    input wire logic wave_restart,
    input wire logic manual_lamp,
    input wire logic sweep_active,
    input wire logic modulation_active
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ans_ready_a: assert property (
        psel && !penable && clk_en |=> pready) else $error("No answer");
    ready_pulse_a: assert property (
        pready |=> !pready) else $error("Ready too long");
    ready_idle_a: assert property (
        !psel |-> !pready) else $error("Ready while idle");
    err_ready_a: assert property (
        pslverr |-> pready) else $error("Error without ready");
    unmapped_zero_a: assert property (
        pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("Unmapped read not zero");
    burst_excl_a: assert property (
        $rose(wave_run) |-> !sweep_active && !modulation_active)
        else $error("Burst with sweep or modulation");
    restart_run_a: assert property (
        wave_restart |-> ##[0:2] wave_run) else $error("Restart no run");
    lamp_idle_a: assert property (
        $rose(manual_lamp) |-> !wave_run) else $error("Lamp while running");
    // ****************************************
    // Covers
    // ****************************************
    burst_start_c: cover property ($rose(wave_run));
    slverr_c: cover property (pslverr);
    lamp_c: cover property ($rose(manual_lamp));
endmodule
bind bts_top bts_chk u_chk (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_in(trig_in), .cycle_end(cycle_end),
    .trig_out(trig_out), .trig_out_oe(trig_out_oe), .wave_run(wave_run),
    .wave_restart(wave_restart), .manual_lamp(manual_lamp),
    .sweep_active(sweep_active), .modulation_active(modulation_active));

// File: testbench/bts_far.sv
// Trigger pin source and waveform engine model
`timescale 1ns/1ns
module bts_far (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wave_run,
    output logic cycle_end,
    output logic trig_in
);
    // ****************************************
    // Cycle ends every ten clocks while running
    // ****************************************
    logic [3:0] cnt_q;
    logic lvl;
    assign trig_in = lvl;
    initial lvl = 1'b0;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 4'h0;
            cycle_end <= 1'b0;
        end
        else
        begin
            cycle_end <= wave_run && cnt_q == 4'h8;
            cnt_q <= (wave_run && cnt_q != 4'h9) ? cnt_q + 4'h1 : 4'h0;
        end
    end
    // Pin level changes just after an edge
    task automatic pin(input logic v);
        @(posedge pclk);
        lvl <= v;
    endtask
endmodule

// File: testbench/tb_top.sv
// Testbench for the burst trigger sequencer
`timescale 1ns/1ns
module tb_top;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic trig_in, cycle_end, trig_out, trig_out_oe, wave_run;
    logic wave_restart, manual_lamp, sweep_active, modulation_active;
    logic last_err, to_prev;
    int num_errors, samples_checked, cyc, rsn, rs_last, rs_gap, ends;
    int to_last, to_gap, r0, w;
    bts_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_in(trig_in), .cycle_end(cycle_end),
        .trig_out(trig_out), .trig_out_oe(trig_out_oe),
        .wave_run(wave_run), .wave_restart(wave_restart),
        .manual_lamp(manual_lamp), .sweep_active(sweep_active),
        .modulation_active(modulation_active));
    bts_far ptr (.pclk(pclk), .presetn(presetn), .wave_run(wave_run),
        .cycle_end(cycle_end), .trig_in(trig_in));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic summarize;
        $display("Checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdv = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rdv, e);
    endtask
    task automatic waitrun;
        while (wave_run === 1'b1)
            @(posedge pclk);
    endtask
    // ****************************************
    // Clock, monitor and timeout
    // ****************************************
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (wave_restart === 1'b1)
        begin
            rsn++;
            rs_gap = cyc - rs_last;
            rs_last = cyc;
        end
        if (cycle_end === 1'b1 && wave_run === 1'b1)
            ends++;
        if (trig_out === 1'b1 && to_prev !== 1'b1)
        begin
            to_gap = cyc - to_last;
            to_last = cyc;
        end
        to_prev = trig_out;
        if (cyc == 20000)
        begin
            num_errors++;
            summarize();
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("ctrl", bts_pkg::ADDR_CTRL, 32'h0);
        rdc("ncyc", bts_pkg::ADDR_NCYC, 32'h1);
        rdc("per", bts_pkg::ADDR_PER, 32'h000f4240);
        rdc("unmapped", 8'h1c, 32'h0);
        chk("slverr", last_err, 32'h1);
        wr(bts_pkg::ADDR_NCYC, 32'h0000c351);
        rdc("ncyc max", bts_pkg::ADDR_NCYC, 32'h1);
        wr(bts_pkg::ADDR_NCYC, 32'h3);
        wr(bts_pkg::ADDR_PER, 32'd200);
        wr(bts_pkg::ADDR_CTRL, 32'h200);
        chk("sweep", sweep_active, 32'h1);
        wr(bts_pkg::ADDR_CTRL, 32'h201);
        rdc("excl", bts_pkg::ADDR_CTRL, 32'h1);
        chk("sweep off", sweep_active, 32'h0);
        wr(bts_pkg::ADDR_CTRL, 32'h2);
        wr(bts_pkg::ADDR_PHASE, 32'h400);
        rdc("rad", bts_pkg::ADDR_PHDEG, (32'h400 * bts_pkg::RAD2DEG)
            >> bts_pkg::RAD2DEG_SHIFT);
        wr(bts_pkg::ADDR_CTRL, 32'h0);
        wr(bts_pkg::ADDR_PHASE, 32'h5a0);
        rdc("deg", bts_pkg::ADDR_PHDEG, 32'h5a0);
        wr(bts_pkg::ADDR_CTRL, 32'h85);
        r0 = rsn;
        repeat (500) @(posedge pclk);
        chk("ext idle", rsn - r0, 32'h0);
        chk("ext oe", trig_out_oe, 32'h0);
        clk_en <= 1'b0;
        ptr.pin(1'b1);
        repeat (20) @(posedge pclk);
        ptr.pin(1'b0);
        clk_en <= 1'b1;
        repeat (10) @(posedge pclk);
        chk("frozen", rsn - r0, 32'h0);
        ptr.pin(1'b1);
        repeat (15) @(posedge pclk);
        ptr.pin(1'b0);
        repeat (4) @(posedge pclk);
        ptr.pin(1'b1);
        waitrun();
        ptr.pin(1'b0);
        repeat (60) @(posedge pclk);
        chk("ext bursts", rsn - r0, 32'h1);
        wr(bts_pkg::ADDR_CTRL, 32'h25);
        r0 = rsn;
        ptr.pin(1'b1);
        repeat (60) @(posedge pclk);
        chk("fall rise", rsn - r0, 32'h0);
        ptr.pin(1'b0);
        repeat (60) @(posedge pclk);
        chk("fall", rsn - r0, 32'h1);
        wr(bts_pkg::ADDR_CMD, 32'h1 << bts_pkg::CMD_TRIG);
        repeat (60) @(posedge pclk);
        chk("generic", rsn - r0, 32'h2);
        wr(bts_pkg::ADDR_CMD, 32'h1 << bts_pkg::CMD_TRG);
        repeat (60) @(posedge pclk);
        chk("bus in ext", rsn - r0, 32'h2);
        wr(bts_pkg::ADDR_CTRL, 32'h89);
        repeat (5) @(posedge pclk);
        chk("lamp", manual_lamp, 32'h1);
        wr(bts_pkg::ADDR_CMD, 32'h1 << bts_pkg::CMD_OPC);
        r0 = ends;
        wr(bts_pkg::ADDR_CMD, 32'h1 << bts_pkg::CMD_TRG);
        while (trig_out !== 1'b1)
            @(posedge pclk);
        w = 0;
        while (trig_out === 1'b1)
        begin
            @(posedge pclk);
            w++;
        end
        chk("pulse", w - 1 > 100, 32'h1);
        waitrun();
        chk("cycles", ends - r0, 32'h3);
        apb(1'b0, bts_pkg::ADDR_STAT, 32'h0);
        chk("opc", rdv[4], 32'h1);
        wr(bts_pkg::ADDR_CMD, 32'h1 << bts_pkg::CMD_COMBINED_SETUP_COMMAND);
        rdc("combined_setup_command", bts_pkg::ADDR_CTRL, 32'h81);
        repeat (700) @(posedge pclk);
        chk("period", rs_gap, 32'd200);
        chk("out period", to_gap, 32'd200);
        chk("int oe", trig_out_oe, 32'h1);
        summarize();
    end
endmodule
